// ---- core/vacuum_suction_regulator.sv ----
// Purpose: suction valve decision logic with valve protection
// Assumes: sensor and command inputs synchronous to I_CLK
// Notes: registers over APB, one wait state per access
`include "vsr_consts.svh"
`timescale 1ns/1ps
module vacuum_suction_regulator
    import vsr_pkg::*;
#(
    parameter int VW = 16,
    parameter int AW = 12,
    parameter logic [31:0] WINDOW_CYCLES = `VSR_WINDOW_MS * `VSR_CLK_KHZ
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [AW-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [VW-1:0] I_VACUUM,
    input wire logic I_SUCTION_CMD,
    input wire logic I_BLOWOFF_CMD,
    input wire logic I_UNDERVOLT,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_SUCTION_VALVE,
    output logic O_BLOWOFF_VALVE,
    output logic O_PART_PRESENT,
    output logic O_STATUS_RED
);
    ////////////////////////////////////////////////////////////////////
    logic control_on;
    logic protection_disable_select;
    logic nc_variant;
    logic uv_continuous;
    logic [VW-1:0] suction_off_threshold;
    logic [VW-1:0] suction_hysteresis;
    logic [VW-1:0] part_present_threshold;
    logic [VW-1:0] part_present_hysteresis;
    suction_state_t state;
    suction_state_t next_state;
    logic suction_cmd;
    logic blowoff_cmd;
    logic limit_flag;
    logic next_limit_flag;
    logic [VW-1:0] suction_lower;
    logic [VW-1:0] part_lower;
    logic drive_on;
    logic activation;
    logic trip;
    logic [31:0] tick;
    logic [2:0] wptr;
    logic [2:0] act_cnt;
    logic [31:0] old_stamp;
    logic access;
    logic wr_ctrl;

    ////////////////////////////////////////////////////////////////////
    // apb slave
    assign access = I_PSEL && I_PENABLE && O_PREADY;
    assign wr_ctrl = access && I_PWRITE && (I_PADDR == `VSR_ADDR_CTRL);

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (I_CE) begin
            O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
            if (I_PSEL && I_PENABLE && !O_PREADY) begin
                O_PSLVERR <= 1'b0;
                O_PRDATA <= 32'h0000_0000;
                unique case (I_PADDR)
                    `VSR_ADDR_CTRL: O_PRDATA <= {28'h0000000, uv_continuous,
                        nc_variant, protection_disable_select, control_on};
                    `VSR_ADDR_SUCTION_LIM: O_PRDATA <=
                        {suction_hysteresis, suction_off_threshold};
                    `VSR_ADDR_PART_LIM: O_PRDATA <=
                        {part_present_hysteresis, part_present_threshold};
                    `VSR_ADDR_STATUS: O_PRDATA <= {21'h0, act_cnt,
                        state, limit_flag, I_UNDERVOLT, O_PART_PRESENT,
                        drive_on};
                    default: O_PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // control word: locks keep the mode pair consistent
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            control_on <= `VSR_RST_CTRL_ON;
            protection_disable_select <= `VSR_RST_DCS;
            nc_variant <= `VSR_RST_NC;
            uv_continuous <= `VSR_RST_UVC;
        end else if (I_CE && wr_ctrl) begin
            control_on <= I_PWDATA[`VSR_CTRL_ON_BIT] ||
                (control_on && protection_disable_select);
            if (control_on) begin
                protection_disable_select <=
                    I_PWDATA[`VSR_CTRL_DCS_BIT];
            end
            nc_variant <= I_PWDATA[`VSR_CTRL_NC_BIT];
            uv_continuous <= I_PWDATA[`VSR_CTRL_UVC_BIT];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            suction_off_threshold <= VW'(`VSR_RST_H1);
            suction_hysteresis <= VW'(`VSR_RST_HYS1);
            part_present_threshold <= VW'(`VSR_RST_H2);
            part_present_hysteresis <= VW'(`VSR_RST_HYS2);
        end else if (I_CE && access && I_PWRITE) begin
            if (I_PADDR == `VSR_ADDR_SUCTION_LIM) begin
                suction_off_threshold <= I_PWDATA[VW-1:0];
                suction_hysteresis <= I_PWDATA[16+VW-1:16];
            end
            if (I_PADDR == `VSR_ADDR_PART_LIM) begin
                part_present_threshold <= I_PWDATA[VW-1:0];
                part_present_hysteresis <= I_PWDATA[16+VW-1:16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command inputs are frozen while the supply is low
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            suction_cmd <= 1'b0;
            blowoff_cmd <= 1'b0;
        end else if (I_CE && !I_UNDERVOLT) begin
            suction_cmd <= I_SUCTION_CMD;
            blowoff_cmd <= I_BLOWOFF_CMD;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // upper limit comparator, always evaluated with hysteresis
    assign suction_lower = (suction_off_threshold > suction_hysteresis) ?
        suction_off_threshold - suction_hysteresis : '0;
    assign part_lower = (part_present_threshold > part_present_hysteresis) ?
        part_present_threshold - part_present_hysteresis : '0;

    always_comb begin
        next_limit_flag = limit_flag;
        if (I_VACUUM >= suction_off_threshold) begin
            next_limit_flag = 1'b1;
        end else if (I_VACUUM < suction_lower) begin
            next_limit_flag = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            limit_flag <= 1'b0;
        end else if (I_CE) begin
            limit_flag <= next_limit_flag;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PART_PRESENT <= 1'b0;
        end else if (I_CE) begin
            if (I_VACUUM >= part_present_threshold) begin
                O_PART_PRESENT <= 1'b1;
            end else if (I_VACUUM < part_lower) begin
                O_PART_PRESENT <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // suction cycle state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (suction_cmd) begin
                next_state = (control_on && !I_UNDERVOLT) ?
                    ST_REGULATE : ST_CONTINUOUS;
            end
            ST_REGULATE: if (!suction_cmd) begin
                next_state = ST_IDLE;
            end else if (I_UNDERVOLT || !control_on) begin
                next_state = ST_CONTINUOUS;
            end else if (trip) begin
                next_state = ST_TRIPPED;
            end
            ST_CONTINUOUS: if (!suction_cmd) begin
                next_state = ST_IDLE;
            end else if (control_on && !I_UNDERVOLT) begin
                next_state = ST_REGULATE;
            end
            ST_TRIPPED: if (!suction_cmd) begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state <= ST_IDLE;
        end else if (I_CE) begin
            state <= next_state;
        end
    end

    // continuous states drive full suction; idle only on the uv variant
    always_comb begin
        unique case (state)
            ST_REGULATE: drive_on = !limit_flag;
            ST_CONTINUOUS: drive_on = 1'b1;
            ST_TRIPPED: drive_on = 1'b1;
            default: drive_on = I_UNDERVOLT && uv_continuous;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // valve protection: stamps of recent re-activations
    assign activation = (state == ST_REGULATE) && limit_flag &&
        !next_limit_flag;
    // trade-off: exact sliding window at the price of a small stamp ring
    assign trip = activation && !protection_disable_select &&
        (act_cnt >= 3'(`VSR_TRIP_COUNT)) &&
        ((tick - old_stamp) < WINDOW_CYCLES);

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            tick <= 32'h0000_0000;
        end else if (I_CE) begin
            tick <= tick + 32'h0000_0001;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wptr <= 3'h0;
            act_cnt <= 3'h0;
        end else if (I_CE) begin
            if (state == ST_IDLE) begin
                act_cnt <= 3'h0;
            end else if (activation) begin
                wptr <= wptr + 3'h1;
                if (act_cnt < 3'(`VSR_TRIP_COUNT)) begin
                    act_cnt <= act_cnt + 3'h1;
                end
            end
        end
    end

    vsr_stamp_ram #(
        .WIDTH(32),
        .DEPTH(8),
        .AW(3)
    ) u_stamps (
        .i_clk(I_CLK),
        .i_ce(I_CE),
        .i_we(activation),
        .i_waddr(wptr),
        .i_wdata(tick),
        .i_raddr(wptr - 3'(`VSR_TRIP_COUNT)),
        .o_rdata(old_stamp)
    );

    ////////////////////////////////////////////////////////////////////
    // pin outputs, one flop after the decision
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_SUCTION_VALVE <= `VSR_RST_NC ? 1'b0 : 1'b1;
            O_BLOWOFF_VALVE <= 1'b0;
            O_STATUS_RED <= 1'b0;
        end else if (I_CE) begin
            O_SUCTION_VALVE <= nc_variant ? drive_on : !drive_on;
            O_BLOWOFF_VALVE <= blowoff_cmd && !drive_on;
            O_STATUS_RED <= (state == ST_TRIPPED);
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N || !I_CE);

    a_limit_stops_gen: assert property (
        state == ST_REGULATE && limit_flag |-> !drive_on)
        else $error("generation not stopped at upper limit");
    a_resume_below: assert property (
        state == ST_REGULATE && next_state == ST_REGULATE && activation
        |=> drive_on)
        else $error("generation not resumed below lower limit");
    a_continuous_full: assert property (
        state == ST_CONTINUOUS |-> drive_on ##1 O_SUCTION_VALVE == nc_variant)
        else $error("continuous mode without full suction");
    a_off_lock: assert property (
        wr_ctrl && protection_disable_select && control_on |=> control_on)
        else $error("control switched off with protection disabled");
    a_trip_red: assert property (
        trip && suction_cmd && control_on && !I_UNDERVOLT |=>
        state == ST_TRIPPED ##1 O_STATUS_RED)
        else $error("trip did not force continuous red state");
    a_trip_holds: assert property (
        state == ST_TRIPPED && suction_cmd |=> state == ST_TRIPPED)
        else $error("tripped state left inside the cycle");
    a_no_trip_disabled: assert property (
        protection_disable_select && state == ST_REGULATE && suction_cmd &&
        control_on && !I_UNDERVOLT |=> state == ST_REGULATE)
        else $error("trip while protection disabled");
    a_dcs_lock: assert property (
        wr_ctrl && !control_on |=> $stable(protection_disable_select))
        else $error("protection setting changed with control off");
    a_uv_freeze: assert property (
        I_UNDERVOLT |=> $stable(suction_cmd) && $stable(blowoff_cmd))
        else $error("commands taken during undervoltage");
    a_uv_force: assert property (
        I_UNDERVOLT && uv_continuous |-> drive_on)
        else $error("undervoltage variant without suction");
    a_part_set: assert property (
        I_VACUUM >= part_present_threshold |=> O_PART_PRESENT)
        else $error("part present not set at threshold");
    a_valve_polarity: assert property (
        $stable(nc_variant) |-> O_SUCTION_VALVE == ($past(drive_on) ^
        !nc_variant))
        else $error("valve polarity wrong for variant");
    a_mode_enable: assert property (
        state == ST_IDLE && suction_cmd && control_on && !I_UNDERVOLT
        |=> state == ST_REGULATE)
        else $error("control setting not honoured at cycle start");
    a_count_clear: assert property (
        state == ST_IDLE |=> act_cnt == 3'h0)
        else $error("activation count not cleared between cycles");

    c_trip: cover property (state == ST_REGULATE ##1 state == ST_TRIPPED);
    c_reactivate: cover property (activation);
    c_part: cover property (!O_PART_PRESENT ##1 O_PART_PRESENT);
    c_uv_cont: cover property (I_UNDERVOLT && state == ST_CONTINUOUS);
endmodule : vacuum_suction_regulator

// ---- core/vsr_consts.svh ----
// Purpose: constants of the vacuum suction regulator
// Assumes: 100 MHz clock, APB register access with 32-bit data
// Notes: offsets are byte addresses
//
// Behaviour
// - control active: stop generation once vacuum reaches the upper limit.
// - regulating: restart generation below upper limit minus hysteresis.
// - control off: continuous full suction, limit only a hysteresis flag.
// - control may be switched off only while protection disable is cleared.
// - over six activations in three seconds: continuous suction, red.
// - after a trip keep continuous suction and red until next suction cycle.
// - protection disable set: keep regulating, never trip on switching rate.
// - protection disable may change only while control is active.
// - undervoltage disables control, freezes suction and blow-off inputs.
// - variant: undervoltage forces suction even if protection disabled.
// - part present sets at threshold, clears below it minus hysteresis.
// - normally-open inverts the nozzle drive, normally-closed passes it.
// - control-mode setting enables or disables the control function.
`ifndef VSR_CONSTS_SVH
`define VSR_CONSTS_SVH

`define VSR_CLK_KHZ 100000
`define VSR_WINDOW_MS 3000
`define VSR_TRIP_COUNT 6

`define VSR_ADDR_CTRL 12'h000
`define VSR_ADDR_SUCTION_LIM 12'h004
`define VSR_ADDR_PART_LIM 12'h008
`define VSR_ADDR_STATUS 12'h00C

`define VSR_CTRL_ON_BIT 0
`define VSR_CTRL_DCS_BIT 1
`define VSR_CTRL_NC_BIT 2
`define VSR_CTRL_UVC_BIT 3

`define VSR_RST_CTRL_ON 1'b1
`define VSR_RST_DCS 1'b0
`define VSR_RST_NC 1'b0
`define VSR_RST_UVC 1'b0
`define VSR_RST_H1 16'h0300
`define VSR_RST_HYS1 16'h0050
`define VSR_RST_H2 16'h0200
`define VSR_RST_HYS2 16'h0050

`endif

// ---- core/vsr_pkg.sv ----
// Purpose: types of the vacuum suction regulator
// Assumes: nothing
// Notes: states are one-hot
package vsr_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_REGULATE = 4'h2,
        ST_CONTINUOUS = 4'h4,
        ST_TRIPPED = 4'h8
    } suction_state_t;
endpackage : vsr_pkg

// ---- core/vsr_stamp_ram.sv ----
// Purpose: small ring of activation time stamps
// Assumes: one write port, one read port
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module vsr_stamp_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset: entries are only read once the count says they are valid
    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : vsr_stamp_ram

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the vacuum suction regulator
// Assumes: protection window shortened to 200 cycles
// Notes: registers mirrored in a model; vacuum from plant or bench
`include "vsr_consts.svh"
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
    localparam logic [15:0] BND [4] = '{16'h0080, 16'h005F, 16'h007F,
        16'h0060};
    localparam logic [31:0] SEQ [6] = '{32'h0, 32'h0, 32'h2, 32'h1,
        32'h3, 32'h0};
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] drv_vac = 16'h0, plant_vac;
    logic cmd = 0, blow = 0, uv = 0, use_plant = 1, nc = 0, last = 0, ce = 1;
    logic pready, pslverr, valve, blow_v, pp, red, nozzle;
    logic [31:0] regs [4];
    int n_errors = 0, n_checks = 0, seed = 40939, k, tog, off, hi;
    ////////////////////////////////////////
    always #5 clk = ~clk;
    assign nozzle = nc ? valve : !valve;
    vacuum_suction_regulator #(.WINDOW_CYCLES(32'd200)) uut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_VACUUM(use_plant ? plant_vac : drv_vac),
        .I_SUCTION_CMD(cmd), .I_BLOWOFF_CMD(blow), .I_UNDERVOLT(uv),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_SUCTION_VALVE(valve), .O_BLOWOFF_VALVE(blow_v),
        .O_PART_PRESENT(pp), .O_STATUS_RED(red));
    vsr_plant plant (.i_clk(clk), .i_valve(valve), .i_nc(nc),
        .o_vacuum(plant_vac));
    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    // refusals judged on the values held before the write
    function automatic logic [31:0] ctrl_next(input logic [31:0] c, d);
        logic [31:0] n;
        n = {28'h0, d[3:0]};
        if (c[1] && c[0]) n[0] = 1'h1;
        if (!c[0]) n[1] = c[1];
        return n;
    endfunction : ctrl_next
    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, 12'(i * 4), d, r, e);
        if (i == 0) regs[0] = ctrl_next(regs[0], d);
        else if (i < 3) regs[i] = d;
    endtask : wr
    task automatic rd(input int i, input logic [31:0] m, x);
        logic [31:0] r;
        logic e;
        apb(1'h0, 12'(i * 4), 32'h0, r, e);
        `CHK(r & m, x & m)
        `CHK(e, i > 3)
    endtask : rd
    task automatic wait_vac(input logic up, input logic [15:0] lim);
        int t = 0;
        while ((up ? plant_vac < lim : plant_vac >= lim) && t < 300) begin
            t++;
            cyc(1);
        end
    endtask : wait_vac
    task automatic watch(input int n);
        tog = 0;
        off = 0;
        hi = 0;
        repeat (n) begin
            cyc(1);
            if (nozzle === 1'h1 && last !== 1'h1) tog++;
            if (nozzle !== 1'h1) off++;
            if (red === 1'h1) hi++;
            last = nozzle;
        end
    endtask : watch
    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////
    initial begin
        cyc(20000);
        n_errors++;
        end_of_test();
    end
    initial begin
        regs[0] = {28'h0, `VSR_RST_UVC, `VSR_RST_NC, `VSR_RST_DCS,
            `VSR_RST_CTRL_ON};
        regs[1] = {`VSR_RST_HYS1, `VSR_RST_H1};
        regs[2] = {`VSR_RST_HYS2, `VSR_RST_H2};
        cyc(12);
        rst_n <= 1'h1;
        for (k = 0; k < 3; k++) rd(k, 32'hFFFFFFFF, regs[k]);
        rd(4, 32'hFFFFFFFF, 32'h0);
        wr(1, 32'h00400100);
        wr(2, 32'h00200080);
        for (k = 1; k < 3; k++) rd(k, 32'hFFFFFFFF, regs[k]);
        for (k = 1; k >= 0; k--) begin
            nc <= k[0];
            wr(0, {29'h0, k[0], 2'h1});
            cmd <= 1'h0;
            cyc(6);
            `CHK(valve, !k[0])
            cmd <= 1'h1;
            cyc(6);
            `CHK(valve, k[0])
            cmd <= 1'h0;
            cyc(80);
        end
        cmd <= 1'h1;
        wait_vac(1'h1, 16'h0100);
        cyc(3);
        `CHK(nozzle, 1'h0)
        wait_vac(1'h0, 16'h00C0);
        cyc(3);
        `CHK(nozzle, 1'h1)
        k = 0;
        while (red !== 1'h1 && k < 400) begin
            k++;
            cyc(1);
        end
        `CHK(red, 1'h1)
        rd(3, 32'h000000F0, 32'h00000080);
        watch(50);
        `CHK(off, 0)
        cmd <= 1'h0;
        cyc(6);
        `CHK(red, 1'h0)
        cyc(80);
        cmd <= 1'h1;
        cyc(5);
        rd(3, 32'h000007F0, 32'h00000020);
        wr(0, 32'h3);
        watch(400);
        `CHK(hi, 0)
        `CHK(tog > 14, 1'h1)
        cmd <= 1'h0;
        cyc(80);
        foreach (SEQ[j]) begin
            wr(0, SEQ[j]);
            rd(0, 32'hFFFFFFFF, regs[0]);
        end
        wr(0, 32'h0);
        cmd <= 1'h1;
        cyc(5);
        watch(100);
        `CHK(off, 0)
        rd(3, 32'h000000F8, 32'h00000048);
        wr(0, 32'h1);
        cmd <= 1'h0;
        cyc(80);
        uv <= 1'h1;
        cyc(2);
        cmd <= 1'h1;
        blow <= 1'h1;
        cyc(10);
        `CHK(nozzle, 1'h0)
        `CHK(blow_v, 1'h0)
        rd(3, 32'h000000F5, 32'h00000014);
        uv <= 1'h0;
        blow <= 1'h0;
        cyc(6);
        `CHK(nozzle, 1'h1)
        cmd <= 1'h0;
        blow <= 1'h1;
        cyc(6);
        `CHK(blow_v, 1'h1)
        blow <= 1'h0;
        cyc(80);
        wr(0, 32'hB);
        uv <= 1'h1;
        cyc(6);
        `CHK(nozzle, 1'h1)
        uv <= 1'h0;
        use_plant <= 1'h0;
        hi = 0;
        for (k = 0; k < 300; k++) begin
            if (k[0])
                drv_vac <= 16'(($random(seed) & 32'hFF) + 32'h20);
            else
                drv_vac <= BND[k[2:1]];
            cyc(2);
            if (drv_vac >= 16'h0080) hi = 1;
            else if (drv_vac < 16'h0060) hi = 0;
            `CHK(pp, hi[0])
        end
        // clock enable low must freeze the part present output
        ce <= 1'h0;
        drv_vac <= hi[0] ? 16'h0000 : 16'h0100;
        cyc(4);
        `CHK(pp, hi[0])
        ce <= 1'h1;
        cyc(2);
        `CHK(pp, !hi[0])
        end_of_test();
    end
endmodule : tb

// ---- tb/vsr_plant.sv ----
// Purpose: vacuum plant behind the suction valve of the regulator
// Assumes: nozzle polarity follows the variant input
// Notes: linear rise and leak, capped so the level never wraps
`timescale 1ns/1ps
module vsr_plant #(
    parameter int RISE = 16,
    parameter int LEAK = 16
) (
    input wire logic i_clk,
    input wire logic i_valve,
    input wire logic i_nc,
    output logic [15:0] o_vacuum
);
    logic nozzle;
    ////////////////////////////////////////
    // the plant does not care which variant, only if air flows
    assign nozzle = i_nc ? i_valve : !i_valve;
    initial o_vacuum = 16'h0000;
    always @(posedge i_clk) begin
        if (nozzle) begin
            if (o_vacuum >= 16'h0400 - 16'(RISE))
                o_vacuum <= 16'h0400;
            else
                o_vacuum <= o_vacuum + 16'(RISE);
        end else if (o_vacuum < 16'(LEAK))
            o_vacuum <= 16'h0000;
        else
            o_vacuum <= o_vacuum - 16'(LEAK);
    end
endmodule : vsr_plant
